// File: core/efs_top.sv
// External FIFO scratch port: host register slave and external bus control
//
// Summary of operation
// - External path works beside UART; 16-byte UART FIFOs and serial untouched.
// - With mode on, reads of offset 07H return the external bus byte.
// - With mode on, writes at scratch offset go out to external FIFOs.
// - On a write in mode, drive the written byte after the cycle starts.
// - Keep the written byte driven until next write; release on reads.
// - Read cycle tri-states the lines, then re-drives them after the read.
`timescale 1ns/1ns
module efs_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External FIFO data bus
  input wire logic [7:0] ext_fifo_data_bus_i,
  output logic [7:0] ext_fifo_data_bus_o,
  output logic ext_fifo_data_bus_oe,
  // External FIFO strobes
  output logic ext_fifo_wr_stb,
  output logic ext_fifo_rd_stb,
  // Status
  output logic ext_mode_on,
  output logic wbuf_ready
);
  // ==========================================================
  // Decode
  // ==========================================================
  efs_pkg::efs_req_type req;
  efs_pkg::efs_state_type st_q;
  efs_pkg::efs_state_type st_d;
  logic [7:0] ctrl_q;
  logic [7:0] scratch_q;
  logic [7:0] rdata_q;
  logic [3:0] cnt_q;
  logic ext_en;
  logic scr_wr;
  logic scr_rd;
  logic buf_valid;
  logic [7:0] buf_data;
  logic drain;
  logic drv_load;
  logic drv_on;
  logic drv_on_q;
  logic wr_stb_q;
  logic pin_oe;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  assign ext_en = ctrl_q[efs_pkg::CTRL_EXT_EN_BIT];
  assign scr_wr = req.wr && hit(req.addr, efs_pkg::SCRATCH_OFS);
  assign scr_rd = req.rd && hit(req.addr, efs_pkg::SCRATCH_OFS);

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= efs_pkg::CTRL_RST;
    end else if (req.wr && hit(req.addr, efs_pkg::CTRL_OFS)) begin
      ctrl_q <= {7'h00, req.wdata[efs_pkg::CTRL_EXT_EN_BIT]};
    end
  end

  // Plain scratch storage only while the mode is off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scratch_q <= efs_pkg::SCRATCH_RST;
    end else if (scr_wr && !ext_en) begin
      scratch_q <= req.wdata;
    end
  end

  // Read data one cycle after the strobe, zero when not reading
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      if (hit(req.addr, efs_pkg::SCRATCH_OFS)) begin
        rdata_q <= ext_en ? ext_fifo_data_bus_i : scratch_q;
      end else if (hit(req.addr, efs_pkg::CTRL_OFS)) begin
        rdata_q <= ctrl_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign ext_mode_on = ext_en;

  // ==========================================================
  // Write buffer toward the external FIFOs
  // ==========================================================
  // Drained only when no read owns the bus; host writes into a full buffer are dropped
  assign drain = (st_q == efs_pkg::EFS_IDLE) && !scr_rd;

  efs_fifo #(
    .WIDTH(efs_pkg::DATA_W),
    .DEPTH(efs_pkg::BUF_DEPTH)
  ) u_wbuf (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(scr_wr && ext_en),
    .in_ready(wbuf_ready),
    .in_data(req.wdata),
    .out_valid(buf_valid),
    .out_ready(drain),
    .out_data(buf_data)
  );

  assign drv_load = buf_valid && drain;

  // ==========================================================
  // Read cycle sequencer
  // ==========================================================
  // Release, sample phase, then re-drive; UART core is not touched
  always_comb begin
    st_d = st_q;
    case (st_q)
      efs_pkg::EFS_IDLE: begin
        if (scr_rd && ext_en) begin
          st_d = efs_pkg::EFS_RELEASE;
        end
      end
      efs_pkg::EFS_RELEASE: begin
        st_d = efs_pkg::EFS_STROBE;
      end
      efs_pkg::EFS_STROBE: begin
        // Fixed strobe; the host pacing is not stretched
        if (cnt_q == 4'(efs_pkg::READ_HOLD_CYC - 1)) begin
          st_d = efs_pkg::EFS_REDRIVE;
        end
      end
      efs_pkg::EFS_REDRIVE: begin
        st_d = efs_pkg::EFS_IDLE;
      end
      default: begin
        st_d = efs_pkg::EFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= efs_pkg::EFS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
    end else if (st_q == efs_pkg::EFS_STROBE) begin
      cnt_q <= cnt_q + 4'h1;
    end else begin
      cnt_q <= 4'h0;
    end
  end

  // Lines are driven once a byte has been written, until the mode is switched off
  always_ff @(posedge core_clk) begin
    if (srst || !ext_en) begin
      drv_on_q <= 1'b0;
    end else if (drv_load) begin
      drv_on_q <= 1'b1;
    end
  end

  // Released during read phases, re-driven afterward
  assign drv_on = ext_en && (drv_on_q || drv_load) && !(scr_rd && ext_en)
                  && (st_d == efs_pkg::EFS_IDLE ||
                      st_d == efs_pkg::EFS_REDRIVE);

  efs_pin_drv u_drv (
    .core_clk(core_clk),
    .srst(srst),
    .load(drv_load),
    .load_data(buf_data),
    .drive(drv_on),
    .pin_o(ext_fifo_data_bus_o),
    .pin_oe(pin_oe)
  );

  // Strobe spans the cycle the byte stands; far side latches at its end.
  // A strobe that meets a read waits for the re-drive, else the far
  // FIFO would latch its own answer instead of the written byte.
  always_ff @(posedge core_clk) begin
    if (srst || !ext_en) begin
      wr_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= drv_load || (wr_stb_q && !ext_fifo_data_bus_oe);
    end
  end

  assign ext_fifo_wr_stb = wr_stb_q && ext_fifo_data_bus_oe;
  assign ext_fifo_rd_stb = ext_en && scr_rd;
  // Lines let go in the read cycle itself so the far side can answer
  assign ext_fifo_data_bus_oe = pin_oe && !ext_fifo_rd_stb;
endmodule

// File: shared/efs_pkg.sv
// Package: register map, field layout and types for the external FIFO port
package efs_pkg;
  localparam int unsigned REG_AW = 3;
  localparam int unsigned DATA_W = 8;
  // Printed scratch offset
  localparam logic [2:0] SCRATCH_OFS = 3'h7;
  // Control register of our own choosing
  localparam logic [2:0] CTRL_OFS = 3'h6;
  localparam int unsigned CTRL_EXT_EN_BIT = 0;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] EXT_BUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Internal UART FIFO depth kept untouched by this path
  localparam int unsigned UART_FIFO_DEPTH = 16;
  localparam int unsigned BUF_DEPTH = 8;
  // Read cycle: strobe phase and release timing in cycles
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned READ_HOLD_NS = 165;
  localparam int unsigned READ_HOLD_CYC = (READ_HOLD_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } efs_req_type;

  typedef enum logic [1:0] {
    EFS_IDLE = 2'b00,
    EFS_RELEASE = 2'b01,
    EFS_STROBE = 2'b11,
    EFS_REDRIVE = 2'b10
  } efs_state_type;
endpackage

// File: core/efs_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module efs_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_q <= '0;
    end else if (in_valid && !full) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rp_q <= '0;
    end else if (out_ready && !empty) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// File: core/efs_pin_drv.sv
// Output register and enable for the external FIFO data lines
`timescale 1ns/1ns
module efs_pin_drv (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic drive,
  // Pins
  output logic [7:0] pin_o,
  output logic pin_oe
);
  logic [7:0] dat_q;
  logic oe_q;

  // Byte persists until the next load
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dat_q <= efs_pkg::EXT_BUS_RST;
    end else if (load) begin
      dat_q <= load_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= drive;
    end
  end

  assign pin_o = dat_q;
  assign pin_oe = oe_q;
endmodule

// File: dv/efs_top_assertions.sv
// Checker for the external FIFO scratch port pins
`timescale 1ns/1ns
module efs_top_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host port
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // External bus
  input wire logic [7:0] ext_fifo_data_bus_i,
  input wire logic [7:0] ext_fifo_data_bus_o,
  input wire logic ext_fifo_data_bus_oe,
  input wire logic ext_fifo_wr_stb,
  input wire logic ext_fifo_rd_stb,
  input wire logic ext_mode_on
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  logic xrd;
  assign xrd = reg_rd && reg_addr == efs_pkg::SCRATCH_OFS && ext_mode_on;
  // ==========
  // Checks
  rd_strobe_a: assert property (ext_fifo_rd_stb == xrd)
    else $error("read strobe mismatch");
  ext_read_a: assert property (
    xrd |=> reg_rdata == $past(ext_fifo_data_bus_i))
    else $error("read data not from bus");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  bus_release_a: assert property (
    xrd |-> !ext_fifo_data_bus_oe)
    else $error("bus not released");
  release_hold_a: assert property (
    xrd |=> !ext_fifo_data_bus_oe [*8])
    else $error("bus re-driven early");
  stb_driven_a: assert property (
    ext_fifo_wr_stb |-> ext_fifo_data_bus_oe)
    else $error("write strobe while undriven");
  byte_persist_a: assert property (
    $changed(ext_fifo_data_bus_o) |-> ##[0:12] ext_fifo_wr_stb)
    else $error("bus byte changed without write");
  mode_off_a: assert property (
    !ext_mode_on ##1 !ext_mode_on |-> !ext_fifo_data_bus_oe)
    else $error("bus driven with mode off");
endmodule
bind efs_top efs_top_chk chk_u (.core_clk(core_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_fifo_data_bus_i(ext_fifo_data_bus_i),
  .ext_fifo_data_bus_o(ext_fifo_data_bus_o),
  .ext_fifo_data_bus_oe(ext_fifo_data_bus_oe),
  .ext_fifo_wr_stb(ext_fifo_wr_stb), .ext_fifo_rd_stb(ext_fifo_rd_stb),
  .ext_mode_on(ext_mode_on));

// File: dv/efs_ext_fifo_model.sv
// External FIFO chip model: bytes written come back on reads
`timescale 1ns/1ns
module efs_ext_fifo_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Strobes and bus
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] bus,
  output logic [7:0] drv_data,
  output logic drv_en
);
  logic [7:0] mem_q [32];
  logic [4:0] wp_q;
  logic [4:0] rp_q;
  // Drives only as long as the host holds its strobe
  assign drv_en = rd_stb;
  assign drv_data = mem_q[rp_q];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
    end else begin
      if (wr_stb) begin
        mem_q[wp_q] <= bus;
        wp_q <= wp_q + 5'h01;
      end
      if (rd_stb) begin
        rp_q <= rp_q + 5'h01;
      end
    end
  end
endmodule

// File: dv/tb.sv
// Testbench for the external FIFO scratch port
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic oe, wstb, rstb, mode, wrdy, m_en;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, last_q = 8'h00;
  logic [7:0] rdata, bus, bus_o, m_d;
  int num_errors, checks, cyc;
  logic [7:0] rows [5][3] = '{'{8'h07, 8'hA5, 8'hA5},
    '{8'h07, 8'h5A, 8'h5A}, '{8'h03, 8'hFF, 8'h00},
    '{8'h00, 8'h3C, 8'h00}, '{8'h06, 8'h00, 8'h00}};
  // Undriven bus shows the inverse of its last level
  assign bus = oe ? bus_o : m_en ? m_d : ~last_q;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (oe || m_en) last_q <= bus;
  efs_top dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .ext_fifo_data_bus_i(bus),
    .ext_fifo_data_bus_o(bus_o), .ext_fifo_data_bus_oe(oe),
    .ext_fifo_wr_stb(wstb), .ext_fifo_rd_stb(rstb), .ext_mode_on(mode),
    .wbuf_ready(wrdy));
  efs_ext_fifo_model far_u (.core_clk(core_clk), .srst(srst),
    .wr_stb(wstb), .rd_stb(rstb), .bus(bus), .drv_data(m_d),
    .drv_en(m_en));
  task chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Leaves the write strobe up so writes can run back to back
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", rdata, e);
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk("rst", {3'h0, oe, mode, wrdy, wstb, rstb}, 8'h04);
    chk("rst bus_o", bus_o, 8'h00);
    @(posedge core_clk);
    foreach (rows[i]) begin
      wr(rows[i][0][2:0], rows[i][1]);
      rd(rows[i][0][2:0], rows[i][2]);
    end
    wr(3'h6, 8'h01);
    wr(3'h7, 8'h3C);
    wr(3'h7, 8'hC3);
    reg_wr <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk("oe", {7'h00, oe}, 8'h01);
    chk("bus_o", bus_o, 8'hC3);
    @(posedge core_clk);
    rd(3'h7, 8'h3C);
    // Fill the write buffer while the bus is held released
    for (int i = 0; i < 8; i++) begin
      wr(3'h7, 8'h10 + i[7:0]);
    end
    reg_wr <= 1'b0;
    @(negedge core_clk);
    chk("wbuf_ready", {7'h00, wrdy}, 8'h00);
    repeat (40) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      rd(3'h7, i == 0 ? 8'hC3 : 8'h0F + i[7:0]);
      repeat (14) @(posedge core_clk);
    end
    @(negedge core_clk);
    chk("redrive", {7'h00, oe}, 8'h01);
    chk("bus_o", bus_o, 8'h17);
    @(posedge core_clk);
    // Strobe that would fall in a read cycle must wait for the re-drive
    wr(3'h7, 8'h66);
    reg_wr <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(3'h7, 8'h77);
    reg_wr <= 1'b0;
    @(posedge core_clk);
    rd(3'h7, 8'h66);
    repeat (14) @(posedge core_clk);
    rd(3'h7, 8'h77);
    repeat (14) @(posedge core_clk);
    @(negedge core_clk);
    chk("bus_o", bus_o, 8'h77);
    @(posedge core_clk);
    wr(3'h6, 8'h00);
    rd(3'h7, 8'h5A);
    end_sim;
  end
endmodule
